// File: src/onchip_osc_master_clock_select.sv
// On-chip oscillator enable, routing, user divider and master clock select.
//
// Behaviour
// - Oscillator runs only when the programming bit and the user enable are both set.
// - Oscillator clock is steered either to the clock tree or to the PLL reference.
// - Oscillator clock can be divided by a user-chosen tick count before use.
// - After reset the master clock runs at its default 2.08 MHz rate.
// - Master clock changes rate only after the configuration selection bits arrive.
// - A default selection, or none at all, keeps the master clock at 2.08 MHz.
// - Only the twenty-one menu codes are accepted; other codes are refused.
//
// Each CLK_IN edge stands for one tick at twice the oscillator rate, so the
// undivided 133 MHz menu entry is a period of two ticks.
// Oscillator disable is abrupt: the running phase may be cut short, since the
// source itself stops; rate and route changes are kept free of short phases.
`timescale 1ns/10ps
`default_nettype none
`include "osc_mclk_defines.svh"

module onchip_osc_master_clock_select #(
    parameter int DIV_W = 8
) (
    // Clock and reset.
    input  wire logic                    CLK_IN,
    input  wire logic                    SRST_IN,
    // Oscillator enables.
    input  wire logic                    OSC_PROG_EN_IN,
    input  wire logic                    OSC_USER_EN_IN,
    // Selection bits from the configuration engine.
    input  wire logic                    CFG_SEL_VALID_IN,
    input  wire logic [`MCLK_CODE_W-1:0] CFG_SEL_IN,
    // User routing and division.
    input  wire logic                    ROUTE_PLL_IN,
    input  wire logic [DIV_W-1:0]        USER_DIV_IN,
    // Oscillator status.
    output logic                         OSC_RUN_OUT,
    // Master clock and its state.
    output logic                         MCLK_OUT,
    output logic [`MCLK_CODE_W-1:0]      MCLK_CODE_OUT,
    output logic                         SEL_DONE_OUT,
    output logic                         SEL_REJECT_OUT,
    // Routed user clocks.
    output logic                         DIV_CLK_OUT,
    output logic                         TREE_CLK_OUT,
    output logic                         PLL_REF_OUT
);

    // ------------------------------------------------------------------------
    // Menu of master clock periods
    // ------------------------------------------------------------------------

    // Period in ticks for each menu code; code 0 is the default, code 20 undivided.
    function automatic osc_mclk_pkg::period_t mclk_period(input osc_mclk_pkg::mclk_code_t c);
        unique case (c)
            5'h00:   mclk_period = 8'h80; // 2.08 MHz.
            5'h01:   mclk_period = 8'h6C; // 2.46 MHz.
            5'h02:   mclk_period = 8'h54; // 3.17 MHz.
            5'h03:   mclk_period = 8'h3E; // 4.29 MHz.
            5'h04:   mclk_period = 8'h30; // 5.54 MHz.
            5'h05:   mclk_period = 8'h26; // 7 MHz.
            5'h06:   mclk_period = 8'h20; // 8.31 MHz.
            5'h07:   mclk_period = 8'h1D; // 9.17 MHz.
            5'h08:   mclk_period = 8'h1A; // 10.23 MHz.
            5'h09:   mclk_period = 8'h14; // 13.3 MHz.
            5'h0A:   mclk_period = 8'h12; // 14.78 MHz.
            5'h0B:   mclk_period = 8'h0D; // 20.46 MHz.
            5'h0C:   mclk_period = 8'h0A; // 26.6 MHz.
            5'h0D:   mclk_period = 8'h09; // 29.56 MHz.
            5'h0E:   mclk_period = 8'h08; // 33.25 MHz.
            5'h0F:   mclk_period = 8'h07; // 38 MHz.
            5'h10:   mclk_period = 8'h06; // 44.33 MHz.
            5'h11:   mclk_period = 8'h05; // 53.2 MHz.
            5'h12:   mclk_period = 8'h04; // 66.5 MHz.
            5'h13:   mclk_period = 8'h03; // 88.67 MHz.
            5'h14:   mclk_period = 8'h02; // 133 MHz.
            default: mclk_period = 8'h80; // Codes above the menu never get stored.
        endcase
    endfunction : mclk_period

    // ------------------------------------------------------------------------
    // Oscillator enable and start-up
    // ------------------------------------------------------------------------
    // Settling time in base ticks, rounded up so the wait is never short.
    localparam int STABLE_CYC = `OSC_STABLE_CYC;

    // Oscillator state and the count of settling ticks spent so far.
    osc_mclk_pkg::osc_state_t state;
    osc_mclk_pkg::osc_state_t next_state;
    logic [3:0]               warm_cnt;

    // Both enables must agree; either one alone stops the oscillator.
    wire logic osc_enable = OSC_PROG_EN_IN && OSC_USER_EN_IN;
    wire logic warm_done  = (warm_cnt == 4'(STABLE_CYC - 1));

    // Start-up waits out the settling time so no early edge reaches the outputs.
    always_comb begin
        next_state = state;
        unique case (state)
            osc_mclk_pkg::ST_OFF:  next_state = osc_enable ? osc_mclk_pkg::ST_WARM : state;
            osc_mclk_pkg::ST_WARM: next_state = warm_done ? osc_mclk_pkg::ST_RUN : state;
            osc_mclk_pkg::ST_RUN:  next_state = state;
        endcase
        if (!osc_enable) begin
            next_state = osc_mclk_pkg::ST_OFF;
        end
    end

    // State register and settling counter.
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            state    <= osc_mclk_pkg::ST_OFF;
            warm_cnt <= 4'h0;
        end else begin
            state    <= next_state;
            warm_cnt <= (state == osc_mclk_pkg::ST_WARM) ? warm_cnt + 4'h1 : 4'h0;
        end
    end

    // Run is decoded from the state so both generators start on one edge.
    wire logic osc_run = (state == osc_mclk_pkg::ST_RUN);

    // ------------------------------------------------------------------------
    // Selection capture
    // ------------------------------------------------------------------------
    // Code that the master clock will take at its next period boundary.
    osc_mclk_pkg::mclk_code_t sel_code;

    // Only the first selection after reset counts; later words are ignored.
    wire logic sel_take  = CFG_SEL_VALID_IN && !SEL_DONE_OUT;
    wire logic sel_legal = (CFG_SEL_IN <= `MCLK_CODE_MAX);

    // A refused code leaves the default in place and still ends the wait.
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            sel_code       <= `MCLK_CODE_DEFAULT;
            SEL_DONE_OUT   <= 1'b0;
            SEL_REJECT_OUT <= 1'b0;
        end else begin
            SEL_REJECT_OUT <= sel_take && !sel_legal;
            if (sel_take) begin
                SEL_DONE_OUT <= 1'b1;
                if (sel_legal) begin
                    sel_code <= CFG_SEL_IN;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Master clock generation
    // ------------------------------------------------------------------------
    // Load strobe from the generator marks the edge at which a new period begins.
    logic mclk_load;

    // The generator holds its period until a boundary, which keeps the switch clean.
    phase_clock_gen #(
        .W         (`MCLK_PERIOD_W)
    ) u_mclk_gen (
        .clk_in    (CLK_IN),
        .srst_in   (SRST_IN),
        .run_in    (osc_run),
        .period_in (mclk_period(sel_code)),
        .clk_out   (MCLK_OUT),
        .load_out  (mclk_load)
    );

    // The reported code follows the period the generator has really taken.
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            MCLK_CODE_OUT <= `MCLK_CODE_DEFAULT;
        end else if (mclk_load) begin
            MCLK_CODE_OUT <= sel_code;
        end
    end

    // ------------------------------------------------------------------------
    // User divider and routing
    // ------------------------------------------------------------------------
    // Raw divided clock, its load strobe and the route it currently follows.
    logic div_clk;
    logic div_load;
    logic route_pll;

    // Division below two ticks is raised to two, the undivided rate.
    phase_clock_gen #(
        .W         (DIV_W)
    ) u_user_div (
        .clk_in    (CLK_IN),
        .srst_in   (SRST_IN),
        .run_in    (osc_run),
        .period_in (USER_DIV_IN),
        .clk_out   (div_clk),
        .load_out  (div_load)
    );

    // The route flips only while the divided clock is low, so neither output
    // sees a runt pulse; the price is up to one divided period of latency.
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            route_pll <= 1'b0;
        end else if (div_load) begin
            route_pll <= ROUTE_PLL_IN;
        end
    end

    // A one-cycle lag on every routed clock is the cost of registered outputs.
    // Output stage: every routed clock leaves from its own flip-flop.
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            OSC_RUN_OUT  <= 1'b0;
            DIV_CLK_OUT  <= 1'b0;
            TREE_CLK_OUT <= 1'b0;
            PLL_REF_OUT  <= 1'b0;
        end else begin
            OSC_RUN_OUT  <= osc_run;
            DIV_CLK_OUT  <= div_clk;
            TREE_CLK_OUT <= div_clk && !route_pll;
            PLL_REF_OUT  <= div_clk && route_pll;
        end
    end

endmodule : onchip_osc_master_clock_select
`default_nettype wire

// File: src/osc_mclk_defines.svh
// Constants for the on-chip oscillator and configuration master clock logic.
`ifndef OSC_MCLK_DEFINES_SVH
`define OSC_MCLK_DEFINES_SVH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS      25
`define OSC_STABLE_NS      100
`define OSC_STABLE_CYC     ((`OSC_STABLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// Master clock selection codes
// ----------------------------------------------------------------------------
`define MCLK_CODE_W        5
`define MCLK_CODE_DEFAULT  5'h00
`define MCLK_CODE_MAX      5'h14
`define MCLK_PERIOD_W      8
`define MIN_PERIOD         8'h02

`endif

// File: src/osc_mclk_pkg.sv
// Types shared by the oscillator and master clock logic.
`include "osc_mclk_defines.svh"

package osc_mclk_pkg;

    // ------------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_OFF,
        ST_WARM,
        ST_RUN
    } osc_state_t;

    typedef logic [`MCLK_CODE_W-1:0]   mclk_code_t;
    typedef logic [`MCLK_PERIOD_W-1:0] period_t;

endpackage : osc_mclk_pkg

// File: src/phase_clock_gen.sv
// Divided clock generator whose period changes only at a period boundary or while stopped.
`timescale 1ns/10ps
`default_nettype none
`include "osc_mclk_defines.svh"

module phase_clock_gen #(
    parameter int W = 8
) (
    // Clock and reset.
    input  wire logic         clk_in,
    input  wire logic         srst_in,
    // Control.
    input  wire logic         run_in,
    input  wire logic [W-1:0] period_in,
    // Generated clock and load strobe.
    output logic              clk_out,
    output logic              load_out
);

    // ------------------------------------------------------------------------
    // Period arithmetic
    // ------------------------------------------------------------------------
    logic [W-1:0] cnt;
    logic [W-1:0] period;

    // Periods below two ticks cannot form a high and a low phase.
    function automatic logic [W-1:0] safe_period(input logic [W-1:0] p);
        safe_period = (p < W'(`MIN_PERIOD)) ? W'(`MIN_PERIOD) : p;
    endfunction : safe_period

    // High phase is the rounded-up half, so odd periods stay whole.
    function automatic logic [W-1:0] high_len(input logic [W-1:0] p);
        high_len = p - (p >> 1);
    endfunction : high_len

    // A new period is taken only at the end of a low phase, or while stopped.
    wire logic         at_end      = (cnt == period - W'(1));
    wire logic [W-1:0] next_period = (at_end || !run_in) ? safe_period(period_in) : period;
    wire logic [W-1:0] next_cnt    = at_end ? '0 : cnt + W'(1);
    wire logic         next_clk    = run_in && (next_cnt < high_len(next_period));

    assign load_out = at_end || !run_in;

    // Stopped, the counter parks on the last count so the first run tick starts high.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            period  <= W'(`MIN_PERIOD);
            cnt     <= W'(`MIN_PERIOD) - W'(1);
            clk_out <= 1'b0;
        end else if (!run_in) begin
            period  <= next_period;
            cnt     <= next_period - W'(1);
            clk_out <= 1'b0;
        end else begin
            period  <= next_period;
            cnt     <= next_cnt;
            clk_out <= next_clk;
        end
    end

endmodule : phase_clock_gen
`default_nettype wire

// File: testbench/cfg_engine_model.sv
// Configuration engine stand-in that delivers the selection word.
`timescale 1ns/10ps
`default_nettype none
module cfg_engine_model (
    input  wire logic                 clk_in,
    input  wire logic                 send_in,
    input  wire logic                 slow_in,
    input  wire logic                 user_pick_in,
    input  wire logic [4:0]           pick_in,
    output logic                      valid_out = 1'b0,
    output osc_mclk_pkg::mclk_code_t  sel_out = 5'h00
);
    // ------------------------------------------------------------------
    // Delivery
    // ------------------------------------------------------------------
    // A slow answer waits one extra cycle; outside its slot the word flips
    // each cycle so a stale code is never mistaken for a held one.
    logic pend = 1'b0;
    wire  go   = (send_in & ~slow_in) | pend;
    always_ff @(posedge clk_in) begin
        pend      <= send_in & slow_in;
        valid_out <= go;
        sel_out   <= go ? (user_pick_in ? pick_in : 5'h00) : ~sel_out;
    end
endmodule : cfg_engine_model
`default_nettype wire

// File: testbench/osc_mclk_checker_assertions.sv
// Port-level timing checks for the oscillator and master clock block.
`timescale 1ns/10ps
`default_nettype none
`include "osc_mclk_defines.svh"
module osc_mclk_checker #(parameter int DIV_W = 8) (
    input wire logic CLK_IN, SRST_IN, OSC_PROG_EN_IN, OSC_USER_EN_IN, CFG_SEL_VALID_IN,
    input wire logic ROUTE_PLL_IN, OSC_RUN_OUT, MCLK_OUT, SEL_DONE_OUT, SEL_REJECT_OUT,
    input wire logic DIV_CLK_OUT, TREE_CLK_OUT, PLL_REF_OUT,
    input wire logic [`MCLK_CODE_W-1:0] CFG_SEL_IN, MCLK_CODE_OUT,
    input wire logic [DIV_W-1:0] USER_DIV_IN
);
    // ------------------------------------------------------------------
    // Phase run lengths
    // ------------------------------------------------------------------
    // Counters stand in for repetitions far too long to unroll.
    localparam int PER [21] = '{128,108,84,62,48,38,32,29,26,20,18,13,10,9,8,7,6,5,4,3,2};
    wire osc_en = OSC_PROG_EN_IN & OSC_USER_EN_IN;
    int  hi_cnt, lo_cnt;
    always_ff @(posedge CLK_IN) begin
        hi_cnt <= (MCLK_OUT && !SRST_IN) ? hi_cnt + 1 : 0;
        lo_cnt <= (!MCLK_OUT && !SRST_IN) ? lo_cnt + 1 : 0;
    end
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (SRST_IN);
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    // Edges caused by an enable drop are excluded; that stop may cut a phase.
    a_release_quiet: assert property ($fell(SRST_IN) |-> !MCLK_OUT && !OSC_RUN_OUT
        && !SEL_DONE_OUT && MCLK_CODE_OUT == 5'h00) else $error("outputs not clear");
    a_enable_pair: assert property (!osc_en |-> ##2 !OSC_RUN_OUT && !MCLK_OUT)
        else $error("oscillator not stopped");
    a_run_warmup: assert property ($rose(OSC_RUN_OUT) |-> MCLK_OUT && $past(osc_en, 4))
        else $error("early run");
    a_route_pick: assert property ((TREE_CLK_OUT || PLL_REF_OUT) |-> DIV_CLK_OUT
        && TREE_CLK_OUT != PLL_REF_OUT) else $error("bad routing");
    a_div_four: assert property ($rose(DIV_CLK_OUT) && USER_DIV_IN == 4 && osc_en
        && $past(USER_DIV_IN, 8) == 4 |-> ##1 DIV_CLK_OUT ##1 !DIV_CLK_OUT[*2])
        else $error("divide by four shape");
    a_mclk_high: assert property ($fell(MCLK_OUT) && $past(OSC_RUN_OUT) && $past(osc_en)
        && $past(osc_en, 2) |-> hi_cnt == (PER[MCLK_CODE_OUT] + 1) / 2) else $error("high phase");
    // A low phase ends at the boundary that loads a new code, so it belongs to the old one.
    a_mclk_low: assert property ($rose(MCLK_OUT) && $past(OSC_RUN_OUT) && $past(osc_en)
        && $past(osc_en, 2) |-> lo_cnt == PER[$past(MCLK_CODE_OUT)] / 2)
        else $error("low phase");
    a_done_sticky: assert property (CFG_SEL_VALID_IN || SEL_DONE_OUT |=> SEL_DONE_OUT)
        else $error("done lost");
    a_code_default: assert property (!SEL_DONE_OUT |-> MCLK_CODE_OUT == 5'h00)
        else $error("early switch");
    a_code_once: assert property ($changed(MCLK_CODE_OUT) |-> $past(MCLK_CODE_OUT) == 5'h00
        && MCLK_CODE_OUT <= 5'h14) else $error("code change");
    a_reject_pulse: assert property (CFG_SEL_VALID_IN && !SEL_DONE_OUT && CFG_SEL_IN > 5'h14
        |=> SEL_REJECT_OUT ##1 !SEL_REJECT_OUT) else $error("no reject");
    c_top_rate: cover property (SEL_DONE_OUT && MCLK_CODE_OUT == 5'h14);
    c_reject: cover property (SEL_REJECT_OUT);
    c_pll: cover property (PLL_REF_OUT);
endmodule : osc_mclk_checker
`default_nettype wire

// File: testbench/test_onchip_osc_master_clock_select.sv
// Self-checking bench for oscillator enable, routing and master clock select.
`timescale 1ns/10ps
`default_nettype none
module test_onchip_osc_master_clock_select;
    logic clk = 1'b0, srst = 1'b1, prog_en = 1'b1, user_en = 1'b1, route = 1'b0;
    logic send = 1'b0, slow = 1'b0, pick_on = 1'b1;
    logic [7:0] div = 8'h04;
    osc_mclk_pkg::mclk_code_t pick = 5'h00, code, sel;
    logic sel_valid, run, mclk, done, rej, dclk, tree, pll;
    int err_total = 0, tests_run = 0, hi, lo, p, e, c, q[$];
    int per [21] = '{128,108,84,62,48,38,32,29,26,20,18,13,10,9,8,7,6,5,4,3,2};
    cfg_engine_model eng (.clk_in(clk), .send_in(send), .slow_in(slow), .user_pick_in(pick_on),
        .pick_in(pick), .valid_out(sel_valid), .sel_out(sel));
    onchip_osc_master_clock_select uut (.CLK_IN(clk), .SRST_IN(srst), .OSC_PROG_EN_IN(prog_en),
        .OSC_USER_EN_IN(user_en), .CFG_SEL_VALID_IN(sel_valid), .CFG_SEL_IN(sel),
        .ROUTE_PLL_IN(route), .USER_DIV_IN(div), .OSC_RUN_OUT(run), .MCLK_OUT(mclk),
        .MCLK_CODE_OUT(code), .SEL_DONE_OUT(done), .SEL_REJECT_OUT(rej),
        .DIV_CLK_OUT(dclk), .TREE_CLK_OUT(tree), .PLL_REF_OUT(pll));
    initial forever #12.5 clk = ~clk;
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    // Inputs move and outputs are read 1 ns after an edge, clear of the race.
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic check(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : check
    // Starts at a fresh rise so a phase cut by an earlier change is never counted.
    task automatic meas(input bit w, output int h, output int l);
        int g;
        g = 0; h = 0; l = 0;
        while ((w ? dclk : mclk) !== 1'b0 && g < 600) begin tick(1); g++; end
        while ((w ? dclk : mclk) !== 1'b1 && g < 600) begin tick(1); g++; end
        while ((w ? dclk : mclk) === 1'b1 && g < 600) begin tick(1); g++; h++; end
        while ((w ? dclk : mclk) === 1'b0 && g < 600) begin tick(1); g++; l++; end
    endtask : meas
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : finish_test
    // ------------------------------------------------------------------
    // Sequence: every menu code once, then one out-of-range code
    // ------------------------------------------------------------------
    initial begin
        p = $urandom(32'h95ec);
        for (c = 0; c <= 21; c++) begin
            div = (c == 0) ? 8'h04 : 8'($urandom_range(15));
            route = 1'($urandom_range(1));
            srst = 1'b1; prog_en = 1'b1; user_en = 1'b1;
            tick(8);
            srst = 1'b0;
            p = 0;
            while (run !== 1'b1 && p < 20) begin tick(1); p++; end
            check(run === 1'b1, "oscillator idle");
            meas(0, hi, lo);
            check(hi == (per[0] + 1) / 2 && lo == per[0] / 2, "default rate");
            // Code 0 stands for no user choice, so the engine sends the default.
            pick = (c == 21) ? 5'($urandom_range(31, 21)) : 5'(c);
            pick_on = (c != 0); slow = c[0];
            send = 1'b1; tick(1); send = 1'b0;
            e = (c == 21) ? 0 : c;
            q.push_back(per[e]);
            hi = 0;
            repeat (6) begin tick(1); if (rej === 1'b1) hi++; end
            check(done === 1'b1 && hi == (c == 21), "selection answer");
            pick = 5'($urandom_range(20)); pick_on = 1'b1;
            send = 1'b1; tick(1); send = 1'b0;
            lo = 0;
            while (code !== 5'(e) && lo < 300) begin tick(1); lo++; end
            meas(0, hi, lo);
            p = q.pop_front();
            check(code === 5'(e) && hi == (p + 1) / 2 && lo == p / 2, "selected rate");
            meas(1, hi, lo);
            meas(1, hi, lo);
            p = (div < 2) ? 2 : div;
            check(hi == (p + 1) / 2 && lo == p / 2, "divided rate");
            check(tree === (dclk & ~route) && pll === (dclk & route), "routing");
            prog_en = c[1]; user_en = ~c[1] & c[2];
            tick(3);
            check(run === 1'b0 && mclk === 1'b0 && dclk === 1'b0, "oscillator stop");
        end
        finish_test();
    end
    // A hang is cut short well past the roughly 11000 cycles the run needs.
    initial begin
        #2000000;
        err_total++;
        finish_test();
    end
endmodule : test_onchip_osc_master_clock_select
bind onchip_osc_master_clock_select osc_mclk_checker #(.DIV_W(DIV_W)) chk (.*);
`default_nettype wire
